// file: pkg/ahbds_pkg.sv
// Purpose: shared codes and types for the 64-to-32 bit AHB downsizer
// Assumes: AHB-Lite encodings of transfer type, size, burst and response
// Notes: the control group of an address phase travels as one packed struct
package ahbds_pkg;
   // ------------------------------------------------------------
   // Widths and address fields
   // ------------------------------------------------------------
   localparam int ADDR_W = 32;
   localparam int WIDE_W = 64;
   localparam int NARROW_W = 32;
   localparam int WORD_BIT = 2;
   localparam logic [ADDR_W-1:0] WRAP16_MASK = 32'h0000007f;

   // ------------------------------------------------------------
   // Bus encodings
   // ------------------------------------------------------------
   localparam logic [1:0] TR_IDLE = 2'h0;
   localparam logic [1:0] TR_BUSY = 2'h1;
   localparam logic [1:0] TR_NONSEQ = 2'h2;
   localparam logic [1:0] TR_SEQ = 2'h3;
   localparam logic [2:0] SZ_32 = 3'h2;
   localparam logic [2:0] SZ_64 = 3'h3;
   localparam logic [2:0] BU_SINGLE = 3'h0;
   localparam logic [2:0] BU_INCR = 3'h1;
   localparam logic [2:0] BU_WRAP4 = 3'h2;
   localparam logic [2:0] BU_INCR4 = 3'h3;
   localparam logic [2:0] BU_WRAP8 = 3'h4;
   localparam logic [2:0] BU_INCR8 = 3'h5;
   localparam logic [2:0] BU_WRAP16 = 3'h6;
   localparam logic [2:0] BU_INCR16 = 3'h7;
   localparam logic RESP_OKAY = 1'h0;
   localparam logic RESP_ERR = 1'h1;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef struct packed {
      logic [1:0] trans;
      logic write;
      logic [2:0] size;
      logic [2:0] burst;
      logic [3:0] prot;
      logic lock;
   } ahbds_ctrl_t;

   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_NARROW = 3'b001,
      S_WIDE1 = 3'b010,
      S_WIDE2 = 3'b011,
      S_REPLAY = 3'b100,
      S_BLK1 = 3'b101,
      S_BLK2 = 3'b110
   } ahbds_state_t;
endpackage : ahbds_pkg

// file: core/ahbds_top.sv
// Purpose: bridge a 64-bit AHB master side onto a 32-bit AHB slave side
// Assumes: one bus clock; unselected narrow slaves answer ready and OKAY
// Notes: read data passes live from the narrow bus, as the merge needs it
//
// Contract
// - Wide transfer becomes two narrow beats
// - Second beat forces address bit two high
// - Write low half first, high half second
// - First read beat data is registered
// - Second beat merges live and stored words
// - Low word first, high word next address
// - Word order ignores system endianness
// - Narrow error forwarded upstream at once
// - First beat error drops second beat
// - Two-cycle error aborts with narrow IDLE
// - Pending request captured, replayed next cycle
// - Replay adds one upstream wait state
// - Continued burst after error answers ERROR
// - Blocking ends on NONSEQ or deselect
// - BUSY during blocking gets OKAY
// - Parameter zero exempts narrow bursts from blocking
// - Error on last beat starts no blocking
// - NONSEQ after last-beat error stalls once
// - Unselected: select low, ready forwarded
// - Narrow passthrough, half routing, read replicate
// - Wide transfer types split, size 32
// - Wide 4- and 8-beat burst types doubled, others become INCR
`timescale 1ns/1ns
module ahbds_top
   import ahbds_pkg::*;
#(
   parameter bit ERR_BURST_BLOCK_ALL = 1'b1
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic upstream_select,
   input wire logic up_ready_in,
   input wire logic [ADDR_W-1:0] upstream_addr,
   input wire ahbds_ctrl_t up_ctrl,
   input wire logic [WIDE_W-1:0] upstream_wdata,
   output logic up_readyout,
   output logic up_resp,
   output logic [WIDE_W-1:0] upstream_rdata,
   output logic downstream_select,
   output logic [ADDR_W-1:0] downstream_addr,
   output ahbds_ctrl_t dn_ctrl,
   output logic [NARROW_W-1:0] dn_wdata,
   output logic dn_ready,
   input wire logic [NARROW_W-1:0] downstream_rdata,
   input wire logic dn_readyout,
   input wire logic dn_resp
);
   // ------------------------------------------------------------
   // Control conversion
   // ------------------------------------------------------------
   // Narrow view of a control group; only wide transfers change
   function automatic ahbds_ctrl_t ahbds_narrow(input ahbds_ctrl_t c, input logic [ADDR_W-1:0] a);
      ahbds_ctrl_t n;
      n = c;
      if (c.size == SZ_64) begin
         n.size = SZ_32;
         case (c.burst)
            BU_SINGLE: n.burst = BU_INCR;
            BU_INCR4: n.burst = BU_INCR8;
            BU_WRAP4: n.burst = BU_WRAP8;
            BU_INCR8: n.burst = BU_INCR16;
            BU_WRAP8: n.burst = BU_WRAP16;
            BU_WRAP16: begin
               // The wrap jump back is not sequential on the narrow side
               n.burst = BU_INCR;
               if (c.trans == TR_SEQ && ~|(a & WRAP16_MASK)) begin
                  n.trans = TR_NONSEQ;
               end
            end
            default: n.burst = BU_INCR;
         endcase
      end
      return n;
   endfunction : ahbds_narrow

   // ------------------------------------------------------------
   // State and decode
   // ------------------------------------------------------------
   ahbds_state_t state;
   ahbds_state_t next_state;
   logic [ADDR_W-1:0] held_addr;
   ahbds_ctrl_t held_ctrl;
   logic [NARROW_W-1:0] rd_low;
   logic block_active;
   logic ds_dp;
   logic resp_err;
   logic err_c1;
   logic err_c2;
   logic take;
   logic req_valid;
   logic req_seq;
   logic req_nonseq;
   logic req_busy;
   logic err_wide;
   logic start_block;
   logic block_mask;
   logic block_now;
   logic replay;
   ahbds_ctrl_t live_ctrl;

   // Request and error classification
   assign ds_dp = (state == S_NARROW) || (state == S_WIDE1) || (state == S_WIDE2);
   assign resp_err = (dn_resp == RESP_ERR);
   assign err_c1 = ds_dp && resp_err && !dn_readyout;
   assign err_c2 = ds_dp && resp_err && dn_readyout;
   assign take = up_ready_in && up_readyout;
   assign req_seq = upstream_select && (up_ctrl.trans == TR_SEQ);
   assign req_nonseq = upstream_select && (up_ctrl.trans == TR_NONSEQ);
   assign req_busy = upstream_select && (up_ctrl.trans == TR_BUSY);
   assign req_valid = req_seq || req_nonseq;
   assign err_wide = (state == S_WIDE1) || (state == S_WIDE2);
   assign live_ctrl = ahbds_narrow(up_ctrl, upstream_addr);

   // narrow bursts blockable only by parameter
   assign start_block = err_c2 && (err_wide || ERR_BURST_BLOCK_ALL);
   // only a SEQ after the error blocks
   assign block_mask = upstream_select && !req_nonseq && (block_active || start_block);
   assign block_now = block_mask && req_seq;
   assign replay = err_c2 && req_valid && !block_now;

   // Next state; a taken address phase overrides the hold paths
   always_comb begin
      next_state = state;
      unique case (state)
         S_WIDE1: begin
            if (dn_readyout && !resp_err) begin
               next_state = S_WIDE2;
            end
         end
         S_REPLAY: next_state = (held_ctrl.size == SZ_64) ? S_WIDE1 : S_NARROW;
         S_BLK1: next_state = S_BLK2;
         S_IDLE, S_NARROW, S_WIDE2, S_BLK2: next_state = state;
         default: next_state = S_IDLE;
      endcase
      if (take) begin
         if (block_now) begin
            next_state = S_BLK1;
         end else if (replay) begin
            next_state = S_REPLAY;
         end else if (!req_valid) begin
            next_state = S_IDLE;
         end else if (up_ctrl.size == SZ_64) begin
            next_state = S_WIDE1;
         end else begin
            next_state = S_NARROW;
         end
      end
   end

   // State register
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         state <= S_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Held address phase, reused for the second beat and the replay
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         held_addr <= '0;
         held_ctrl <= '0;
      end else if (take && req_valid) begin
         held_addr <= upstream_addr;
         held_ctrl <= up_ctrl;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rd_low <= '0;
      end else if (state == S_WIDE1 && dn_readyout && !resp_err) begin
         rd_low <= downstream_rdata;
      end
   end

   // blocking ends on NONSEQ or deselect
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         block_active <= 1'b0;
      end else if (take && (!upstream_select || req_nonseq)) begin
         block_active <= 1'b0;
      end else if (take && block_now) begin
         block_active <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Narrow side address phase
   // ------------------------------------------------------------
   // Live request passes unless a beat, replay or abort owns the bus
   always_comb begin
      downstream_addr = upstream_addr;
      dn_ctrl = live_ctrl;
      downstream_select = upstream_select;
      if (state == S_WIDE1) begin
         downstream_addr = held_addr;
         downstream_addr[WORD_BIT] = 1'b1;
         dn_ctrl = ahbds_narrow(held_ctrl, held_addr);
         dn_ctrl.trans = TR_SEQ;
         downstream_select = 1'b1;
      end else if (state == S_REPLAY) begin
         downstream_addr = held_addr;
         dn_ctrl = ahbds_narrow(held_ctrl, held_addr);
         dn_ctrl.trans = TR_NONSEQ;
         downstream_select = 1'b1;
      end
      if (err_c1 || err_c2 || block_mask || state == S_BLK1) begin
         dn_ctrl.trans = TR_IDLE;
      end
   end

   // Narrow ready: slave ready in our data phase, forced on for replay
   always_comb begin
      if (ds_dp) begin
         dn_ready = dn_readyout;
      end else if (state == S_REPLAY) begin
         dn_ready = 1'b1;
      end else begin
         dn_ready = up_ready_in;
      end
   end

   // ------------------------------------------------------------
   // Data routing
   // ------------------------------------------------------------
   // write halves per beat or address
   always_comb begin
      unique case (state)
         S_WIDE2: dn_wdata = upstream_wdata[WIDE_W-1:NARROW_W];
         S_NARROW: dn_wdata = held_addr[WORD_BIT] ? upstream_wdata[WIDE_W-1:NARROW_W]
                                                  : upstream_wdata[NARROW_W-1:0];
         default: dn_wdata = upstream_wdata[NARROW_W-1:0];
      endcase
   end

   always_comb begin
      if (state == S_WIDE2) begin
         upstream_rdata = {downstream_rdata, rd_low};
      end else begin
         upstream_rdata = {downstream_rdata, downstream_rdata};
      end
   end

   // ------------------------------------------------------------
   // Wide side response
   // ------------------------------------------------------------
   // error forwarded immediately
   always_comb begin
      up_readyout = 1'b1;
      up_resp = RESP_OKAY;
      if (state == S_WIDE1) begin
         up_readyout = resp_err && dn_readyout;
         up_resp = dn_resp;
      end else if (ds_dp) begin
         up_readyout = dn_readyout;
         up_resp = dn_resp;
      end else if (state == S_REPLAY) begin
         up_readyout = 1'b0;
      end else if (state == S_BLK1) begin
         up_readyout = 1'b0;
         up_resp = RESP_ERR;
      end else if (state == S_BLK2) begin
         up_resp = RESP_ERR;
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rstn);

   property p_beat2_addr;
      (state == S_WIDE1 && !resp_err) |-> downstream_addr[WORD_BIT] && dn_ctrl.trans == TR_SEQ;
   endproperty
   a_beat2_addr: assert property (p_beat2_addr) else $error("second beat address wrong");

   property p_wide_start;
      (take && req_valid && !block_now && !replay && up_ctrl.size == SZ_64)
         |-> dn_ctrl.size == SZ_32 ##1 state == S_WIDE1 && !up_readyout || resp_err;
   endproperty
   a_wide_start: assert property (p_wide_start) else $error("wide transfer not split");

   property p_wdata_halves;
      (state == S_WIDE1 |-> dn_wdata == upstream_wdata[NARROW_W-1:0])
         and (state == S_WIDE2 |-> dn_wdata == upstream_wdata[WIDE_W-1:NARROW_W]);
   endproperty
   a_wdata_halves: assert property (p_wdata_halves) else $error("write half misrouted");

   property p_rd_merge;
      (state == S_WIDE1 && dn_readyout && !resp_err)
         |=> state == S_WIDE2 && upstream_rdata[NARROW_W-1:0] == $past(downstream_rdata);
   endproperty
   a_rd_merge: assert property (p_rd_merge) else $error("first read word lost");

   property p_err_fwd;
      (ds_dp && resp_err) |-> up_resp == RESP_ERR && up_readyout == dn_readyout;
   endproperty
   a_err_fwd: assert property (p_err_fwd) else $error("error not forwarded");

   property p_no_beat2;
      (state == S_WIDE1 && err_c2) |=> state != S_WIDE2;
   endproperty
   a_no_beat2: assert property (p_no_beat2) else $error("beat after error issued");

   property p_abort_idle;
      (err_c1 || err_c2) |-> dn_ctrl.trans == TR_IDLE;
   endproperty
   a_abort_idle: assert property (p_abort_idle) else $error("abort not IDLE");

   property p_replay;
      (take && replay) |=> state == S_REPLAY && !up_readyout
         && downstream_addr == $past(upstream_addr) && dn_ctrl.trans == TR_NONSEQ;
   endproperty
   a_replay: assert property (p_replay) else $error("pending request not replayed");

   property p_block;
      (take && block_now) |-> dn_ctrl.trans == TR_IDLE
         ##1 (up_resp == RESP_ERR && !up_readyout) ##1 (up_resp == RESP_ERR && up_readyout);
   endproperty
   a_block: assert property (p_block) else $error("blocked beat not errored");

   property p_busy_ok;
      (take && block_active && req_busy) |=> up_resp == RESP_OKAY && up_readyout && block_active;
   endproperty
   a_busy_ok: assert property (p_busy_ok) else $error("busy in blocking not OKAY");

   property p_unsel;
      (state == S_IDLE && !upstream_select) |-> !downstream_select && dn_ready == up_ready_in;
   endproperty
   a_unsel: assert property (p_unsel) else $error("unselected passthrough wrong");

   property p_narrow_rd;
      state == S_NARROW |-> upstream_rdata == {downstream_rdata, downstream_rdata};
   endproperty
   a_narrow_rd: assert property (p_narrow_rd) else $error("narrow read not replicated");

   c_wide_read: cover property (state == S_WIDE1 ##[1:8] state == S_WIDE2 && dn_readyout);
   c_replay: cover property (err_c1 ##1 err_c2 ##1 state == S_REPLAY);
   c_block: cover property (take && block_now ##2 state == S_BLK2);
   c_busy_block: cover property (take && block_active && req_busy);
endmodule : ahbds_top

// file: test/ahbds_slave.sv
// Purpose: behavioural 32-bit AHB slave behind the bridge
// Assumes: 32-word memory; two word slots always answer ERROR
// Notes: wait states per data phase come from the bench
`timescale 1ns/1ns
module ahbds_slave
   import ahbds_pkg::*;
#(
   parameter logic [4:0] ERR_A = 5'h18,
   parameter logic [4:0] ERR_B = 5'h1f
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic downstream_select,
   input wire logic [ADDR_W-1:0] downstream_addr,
   input wire ahbds_ctrl_t dn_ctrl,
   input wire logic [NARROW_W-1:0] dn_wdata,
   input wire logic dn_ready,
   input wire logic [1:0] wait_req,
   output logic [NARROW_W-1:0] downstream_rdata,
   output logic dn_readyout,
   output logic dn_resp
);
   logic [NARROW_W-1:0] mem [32];
   logic [NARROW_W-1:0] last = '0;
   logic act, wr, err, late;
   logic [4:0] idx;
   logic [1:0] wcnt;
   // ------------------------------------------------------------
   // Data phase sequencing
   // ------------------------------------------------------------
   initial for (int k = 0; k < 32; k++) mem[k] = 32'h5a5a0000 | k;
   // Error is two cycles: ready low first, then high
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         act <= 1'b0;
         late <= 1'b0;
      end else if (dn_ready) begin
         if (act && wr && !err) mem[idx] <= dn_wdata;
         act <= downstream_select && dn_ctrl.trans[1];
         wr <= dn_ctrl.write;
         idx <= downstream_addr[6:2];
         err <= downstream_addr[6:2] inside {ERR_A, ERR_B};
         wcnt <= wait_req;
         late <= 1'b0;
      end else if (act && wcnt != 2'h0) begin
         wcnt <= wcnt - 2'h1;
      end else if (act) begin
         late <= err;
      end
   end
   // Unselected slave answers ready and OKAY
   assign dn_readyout = !act || (wcnt == 2'h0 && (!err || late));
   assign dn_resp = act && wcnt == 2'h0 && err;
   // Idle bus toggles so a stale word never looks valid
   assign downstream_rdata = (act && !wr && wcnt == 2'h0 && !err) ? mem[idx] : ~last;
   always @(posedge core_clk) last <= downstream_rdata;
endmodule : ahbds_slave

// file: test/ahbds_top_test.sv
// Purpose: self-checking bench for the 64-to-32 bit AHB bridge
// Assumes: one wide master in the bench, one narrow slave model
// Notes: expected words come from a shadow of the slave memory
`timescale 1ns/1ns
module ahbds_top_test
   import ahbds_pkg::*;
;
   localparam int LW = ADDR_W + $bits(ahbds_ctrl_t);
   typedef struct packed {
      logic [ADDR_W-1:0] a;
      ahbds_ctrl_t c;
      logic [WIDE_W-1:0] wd;
   } ahbds_req_t;
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic upstream_select = 1'b0;
   logic rdy_hold = 1'b0;
   logic [ADDR_W-1:0] upstream_addr = '0;
   ahbds_ctrl_t up_ctrl = '0;
   logic [WIDE_W-1:0] upstream_wdata = '0;
   logic [1:0] wait_req = 2'h0;
   wire logic up_ready_in;
   logic up_readyout, up_resp, downstream_select, dn_ready, dn_readyout, dn_resp;
   logic [WIDE_W-1:0] upstream_rdata;
   logic [ADDR_W-1:0] downstream_addr;
   ahbds_ctrl_t dn_ctrl;
   logic [NARROW_W-1:0] dn_wdata, downstream_rdata;
   int bad_count = 0;
   int n_checks = 0;
   ahbds_req_t q[$];
   logic e_rsp[$], e_chk[$], rsp_got[$];
   logic [WIDE_W-1:0] e_rd[$], rd_got[$];
   logic [LW-1:0] e_log[$], n_log[$];
   logic [NARROW_W-1:0] e_mem [32];

   // Single slave on the wide bus: its ready is the bus ready
   assign up_ready_in = up_readyout & ~rdy_hold;
   always #5 core_clk = ~core_clk;

   ahbds_top #(.ERR_BURST_BLOCK_ALL(1'b1)) DUT (.core_clk, .rstn, .upstream_select, .up_ready_in,
      .upstream_addr, .up_ctrl, .upstream_wdata, .up_readyout, .up_resp, .upstream_rdata,
      .downstream_select, .downstream_addr, .dn_ctrl, .dn_wdata, .dn_ready, .downstream_rdata,
      .dn_readyout, .dn_resp);
   ahbds_slave SLV (.core_clk, .rstn, .downstream_select, .downstream_addr, .dn_ctrl, .dn_wdata,
      .dn_ready, .wait_req, .downstream_rdata, .dn_readyout, .dn_resp);

   // Log every narrow address phase the slaves accept
   always @(posedge core_clk) begin
      if (rstn && dn_ready && downstream_select && dn_ctrl.trans[1]) n_log.push_back({downstream_addr, dn_ctrl});
   end

   // ------------------------------------------------------------
   // Expectations and comparisons
   // ------------------------------------------------------------
   function automatic logic [2:0] map_burst(logic [2:0] b);
      case (b)
         BU_INCR4: return BU_INCR8;
         BU_WRAP4: return BU_WRAP8;
         BU_INCR8: return BU_INCR16;
         BU_WRAP8: return BU_WRAP16;
         default: return BU_INCR;
      endcase
   endfunction : map_burst

   task automatic chk_word(string nm, logic [WIDE_W-1:0] e, logic [WIDE_W-1:0] g);
      n_checks++;
      if (g !== e) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk_word

   task automatic chk_bit(string nm, logic e, logic g);
      n_checks++;
      if (g !== e) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk_bit

   task automatic chk_phase(string nm, logic [LW-1:0] e, logic [LW-1:0] g);
      n_checks++;
      if (g !== e) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk_phase

   // Queue one request with its response and the narrow phases it makes
   task automatic add(logic [ADDR_W-1:0] a, logic [1:0] tr, logic w, logic [2:0] sz, logic [2:0] bu,
                      logic rsp, int nd);
      ahbds_req_t r;
      logic [4:0] i;
      r.a = a;
      r.c = '{tr, w, sz, bu, 4'($urandom), 1'b0};
      r.wd = {$urandom, $urandom};
      i = a[6:2];
      q.push_back(r);
      e_rsp.push_back(rsp);
      e_chk.push_back(!w && tr[1] && rsp == RESP_OKAY);
      e_rd.push_back(sz == SZ_64 ? {e_mem[i + 5'h1], e_mem[i]} : {2{e_mem[i]}});
      if (w && tr[1] && rsp == RESP_OKAY && sz == SZ_64) {e_mem[i + 5'h1], e_mem[i]} = r.wd;
      else if (w && tr[1] && rsp == RESP_OKAY) e_mem[i] = a[2] ? r.wd[63:32] : r.wd[31:0];
      if (sz == SZ_64) begin
         r.c.size = SZ_32;
         r.c.burst = map_burst(bu);
      end
      if (nd > 0) e_log.push_back({a, r.c});
      r.c.trans = TR_SEQ;
      if (nd > 1) e_log.push_back({a | 32'h4, r.c});
   endtask : add

   task automatic drive(int i);
      upstream_select = 1'b1;
      if (i < q.size()) begin
         upstream_addr = q[i].a;
         up_ctrl = q[i].c;
      end else begin
         up_ctrl.trans = TR_IDLE;
      end
   endtask : drive

   // Runs the queue back to back on the pipelined wide bus, then compares
   task automatic run_q();
      int i, d, k;
      logic rdy;
      i = 0;
      d = -1;
      // Let the idle request of the previous run stand one cycle
      @(negedge core_clk);
      n_log.delete();
      drive(0);
      for (k = 0; k < 300 && (i < q.size() || d >= 0); k++) begin
         #1 rdy = up_ready_in;
         if (rdy && d >= 0) begin
            rsp_got.push_back(up_resp);
            rd_got.push_back(upstream_rdata);
         end
         @(negedge core_clk);
         wait_req = 2'($urandom_range(0, 2));
         if (rdy) begin
            d = i < q.size() ? i : -1;
            i++;
            drive(i);
            if (d >= 0) upstream_wdata = q[d].wd;
         end
      end
      chk_bit("queue drained", 1'b1, k < 300);
      for (k = 0; k < q.size(); k++) begin
         chk_bit("response", e_rsp[k], rsp_got[k]);
         if (e_chk[k]) chk_word("read data", e_rd[k], rd_got[k]);
      end
      chk_word("narrow count", 64'(e_log.size()), 64'(n_log.size()));
      for (k = 0; k < e_log.size(); k++) chk_phase("narrow phase", e_log[k], n_log[k]);
      q.delete();
      e_rsp.delete();
      e_chk.delete();
      e_rd.delete();
      e_log.delete();
      rsp_got.delete();
      rd_got.delete();
   endtask : run_q

   task automatic end_of_test();
      if (bad_count == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : end_of_test

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   initial begin
      #100000;
      bad_count++;
      end_of_test();
   end

   initial begin
      int n, w, b;
      logic [2:0] bl [4];
      void'($urandom(38501));
      for (n = 0; n < 32; n++) e_mem[n] = 32'h5a5a0000 | n;
      repeat (20) @(negedge core_clk);
      rstn = 1'b1;
      // Deselected: narrow select low, ready forwarded
      @(negedge core_clk);
      up_ctrl.trans = TR_NONSEQ;
      rdy_hold = 1'b1;
      #1 chk_bit("narrow select", 1'b0, downstream_select);
      chk_bit("narrow ready", 1'b0, dn_ready);
      @(negedge core_clk);
      rdy_hold = 1'b0;
      #1 chk_bit("narrow ready", 1'b1, dn_ready);
      @(negedge core_clk);
      // Random writes then reads, narrow and wide mixed
      for (n = 0; n < 24; n++) begin
         w = $urandom_range(0, 22);
         b = $urandom_range(0, 1);
         add(b ? 32'(w / 2 * 8) : 32'(w * 4), TR_NONSEQ, n < 12, b ? SZ_64 : SZ_32, BU_SINGLE, RESP_OKAY, b + 1);
      end
      run_q();
      // Every doubled burst kind, bursts back to back
      bl = '{BU_INCR4, BU_WRAP4, BU_INCR8, BU_WRAP8};
      for (b = 0; b < 4; b++) begin
         for (n = 0; n < (b < 2 ? 4 : 8); n++) add(32'(n * 8), n == 0 ? TR_NONSEQ : TR_SEQ, 1'b0, SZ_64, bl[b],
                                                  RESP_OKAY, 2);
      end
      run_q();
      // First-beat error, second-beat error, then NONSEQ replays
      add(32'h60, TR_NONSEQ, 1'b0, SZ_64, BU_SINGLE, RESP_ERR, 1);
      add(32'h78, TR_NONSEQ, 1'b1, SZ_64, BU_SINGLE, RESP_ERR, 2);
      e_mem[30] = q[1].wd[31:0];
      add(32'h08, TR_NONSEQ, 1'b1, SZ_32, BU_SINGLE, RESP_OKAY, 1);
      add(32'h08, TR_NONSEQ, 1'b0, SZ_32, BU_SINGLE, RESP_OKAY, 1);
      run_q();
      // Error inside a wide burst: rest blocked, BUSY answered OKAY; a narrow burst blocks too
      add(32'h50, TR_NONSEQ, 1'b0, SZ_64, BU_INCR, RESP_OKAY, 2);
      add(32'h58, TR_SEQ, 1'b0, SZ_64, BU_INCR, RESP_OKAY, 2);
      add(32'h60, TR_SEQ, 1'b0, SZ_64, BU_INCR, RESP_ERR, 1);
      add(32'h68, TR_SEQ, 1'b0, SZ_64, BU_INCR, RESP_ERR, 0);
      add(32'h70, TR_BUSY, 1'b0, SZ_64, BU_INCR, RESP_OKAY, 0);
      add(32'h70, TR_SEQ, 1'b0, SZ_64, BU_INCR, RESP_ERR, 0);
      add(32'h04, TR_NONSEQ, 1'b0, SZ_32, BU_SINGLE, RESP_OKAY, 1);
      add(32'h5c, TR_NONSEQ, 1'b0, SZ_32, BU_INCR, RESP_OKAY, 1);
      add(32'h60, TR_SEQ, 1'b0, SZ_32, BU_INCR, RESP_ERR, 1);
      add(32'h64, TR_SEQ, 1'b0, SZ_32, BU_INCR, RESP_ERR, 0);
      add(32'h00, TR_NONSEQ, 1'b0, SZ_32, BU_SINGLE, RESP_OKAY, 1);
      run_q();
      for (n = 0; n < 32; n++) chk_word("slave word", 64'(e_mem[n]), 64'(SLV.mem[n]));
      end_of_test();
   end
endmodule : ahbds_top_test
